//--- logic/dma_ctrl_pkg.sv
// constants and carrier types of the dma channel control block
package dma_ctrl_pkg;

    // ----------------------------------------
    // register map, byte addresses
    // ----------------------------------------
    localparam int MAX_CH = 7;
    localparam int ADDR_W = 8;
    localparam logic [7:0] EVENT_STATUS_OFS = 8'h00;
    localparam logic [7:0] EVENT_FLAG_CLEAR_OFS = 8'h04;
    localparam logic [7:0] CH_BASE_OFS = 8'h08;
    localparam logic [7:0] CH_STRIDE = 8'h14;
    localparam logic [7:0] CH_CONFIG_OFS = 8'h00;
    localparam logic [7:0] CH_COUNT_OFS = 8'h04;
    localparam logic [7:0] CH_PADDR_OFS = 8'h08;
    localparam logic [7:0] CH_MADDR_OFS = 8'h0c;

    // ----------------------------------------
    // field layout and reset values
    // ----------------------------------------
    localparam int FLAG_STRIDE = 4;
    localparam int FLAG_ANY_BIT = 0;
    localparam int FLAG_DONE_BIT = 1;
    localparam int FLAG_HALF_BIT = 2;
    localparam int FLAG_FAULT_BIT = 3;
    localparam int STATUS_USED_W = 28;
    localparam int CFG_W = 15;
    localparam int COUNT_W = 16;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    localparam logic [31:0] STEP_8 = 32'h0000_0001;
    localparam logic [31:0] STEP_16 = 32'h0000_0002;
    localparam logic [31:0] STEP_32 = 32'h0000_0004;

    // ----------------------------------------
    // carrier types
    // ----------------------------------------
    typedef struct packed {
        logic memory_copy_enable;
        logic [1:0] channel_priority_level;
        logic [1:0] memory_word_width;
        logic [1:0] periph_word_width;
        logic memory_addr_step_enable;
        logic periph_addr_step_enable;
        logic wraparound_enable;
        logic transfer_direction;
        logic fault_irq_enable;
        logic halfway_irq_enable;
        logic done_irq_enable;
        logic channel_on;
    } chan_cfg_t;

    typedef struct packed {
        logic channel_fault_flag;
        logic channel_halfway_flag;
        logic channel_done_flag;
        logic channel_any_event_flag;
    } chan_flags_t;

    typedef struct packed {
        chan_cfg_t cfg;
        chan_flags_t flags;
        logic [15:0] transfer_quantity;
        logic [15:0] reload_quantity;
        logic [31:0] periph_addr;
        logic [31:0] memory_addr;
        logic [31:0] periph_base;
        logic [31:0] memory_base;
    } chan_state_t;

    typedef struct packed {
        logic valid;
        logic [2:0] channel;
        logic transfer_direction;
        logic [1:0] periph_word_width;
        logic [1:0] memory_word_width;
        logic memory_copy_enable;
        logic [31:0] periph_addr;
        logic [31:0] memory_addr;
    } grant_t;

    typedef struct packed {
        logic hit;
        logic is_chan;
        logic is_clear;
        logic [2:0] chan;
        logic [7:0] reg_ofs;
    } decode_t;

endpackage

//--- logic/dma_channel_control_regs.sv
// apb register file, flags, arbiter and counters of the dma channels
// How it works
// R1: any-event flag set by every channel event
// R2: done flag set when count reaches zero
// R3: halfway flag set at half the count
// R4: fault flag set on a transfer error
// R5: global clear wipes all four channel flags
// R6: single clears hit one flag; zero ignored
// R7: config bit 0 enable, bits 1-3 irqs
// R8: bit 4 selects transfer direction
// R9: bit 5 enables wraparound operation
// R10: bits 6,7 enable address stepping
// R11: bits 9:8 peripheral word width code
// R12: bits 11:10 memory word width code
// R13: bits 13:12 software priority level
// R14: bit 14 enables memory copy mode
// R15: software avoids 8-bit width for some peripherals
// R16: channel registers at 0x08 plus twenty each
// R17: status, clear, config reset to zero
// R18: reserved bits always read as zero
// R19: highest level wins, then lowest channel
// R20: count steps down, zero blocks, wrap reloads
// R21: enabled channel locks address and count writes
// R22: channel irq is enabled flags ored
`timescale 1ns/1ps
module dma_channel_control_regs
    import dma_ctrl_pkg::*;
#(
    parameter int NUM_CH = 7
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CH-1:0] chan_request,
    input wire logic beat_done,
    input wire logic beat_fault,
    output grant_t grant,
    output logic [NUM_CH-1:0] channel_irq
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    if (NUM_CH < 1 || NUM_CH > MAX_CH)
    begin : g_bad_ch
        $error("NUM_CH must lie between 1 and 7");
    end

    if (int'(CH_BASE_OFS) + int'(CH_STRIDE) * NUM_CH > (1 << ADDR_W))
    begin : g_bad_map
        $error("channel map does not fit the address width");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        chan_state_t [MAX_CH-1:0] ch;
        grant_t grant;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [MAX_CH-1:0] irq;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic decode_t decode(input logic [ADDR_W-1:0] a);
        decode_t d;
        logic [7:0] base;
        d = '0;
        base = CH_BASE_OFS;
        if (a == EVENT_STATUS_OFS)
        begin
            d.hit = 1'b1;
        end
        if (a == EVENT_FLAG_CLEAR_OFS)
        begin
            d.hit = 1'b1;
            d.is_clear = 1'b1;
        end
        // R16: channel register blocks
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (a >= base && a <= 8'(base + CH_MADDR_OFS) && a[1:0] == 2'b00)
            begin
                d.hit = 1'b1;
                d.is_chan = 1'b1;
                d.chan = 3'(i);
                d.reg_ofs = 8'(a - base);
            end
            base = 8'(base + CH_STRIDE);
        end
        return d;
    endfunction

    function automatic logic [31:0] step_of(input logic [1:0] w);
        case (w)
            WIDTH_8: step_of = STEP_8;
            WIDTH_16: step_of = STEP_16;
            WIDTH_32: step_of = STEP_32;
            default: step_of = STEP_32;
        endcase
    endfunction

    function automatic logic eligible(input chan_state_t c, input logic req);
        return c.cfg.channel_on && c.transfer_quantity != 16'd0
            && (req || c.cfg.memory_copy_enable);
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        decode_t dec;
        logic rd_phase;
        logic wr_now;
        logic [31:0] rdata;
        logic [MAX_CH-1:0][3:0] flag_set;
        logic [MAX_CH-1:0][3:0] flag_clr;
        logic [2:0] g;
        logic [15:0] left;
        logic found;
        logic [1:0] best_pl;
        logic [2:0] best;
        dec = decode(paddr);
        rd_phase = psel && penable && !state_reg.pready;
        wr_now = psel && penable && state_reg.pready && pwrite;
        rdata = REG_RESET;
        flag_set = '0;
        flag_clr = '0;
        g = state_reg.grant.channel;
        left = '0;
        found = 1'b0;
        best_pl = 2'b00;
        best = 3'd0;
        state_next = state_reg;

        // ----------------------------------------
        // apb: one wait state, data and error ready with pready
        // ----------------------------------------
        state_next.pready = rd_phase;
        state_next.pslverr = rd_phase && !dec.hit;
        if (dec.is_chan)
        begin
            // R18: unused bits read zero
            case (dec.reg_ofs)
                CH_CONFIG_OFS: rdata = 32'(state_reg.ch[dec.chan].cfg);
                CH_COUNT_OFS: rdata = 32'(state_reg.ch[dec.chan].transfer_quantity);
                CH_PADDR_OFS: rdata = state_reg.ch[dec.chan].periph_base;
                CH_MADDR_OFS: rdata = state_reg.ch[dec.chan].memory_base;
                default: rdata = REG_RESET;
            endcase
        end
        else if (dec.hit && !dec.is_clear)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                rdata[FLAG_STRIDE*i +: FLAG_STRIDE] = state_reg.ch[i].flags;
            end
        end
        state_next.prdata = rd_phase ? rdata : REG_RESET;

        // ----------------------------------------
        // drop a grant whose channel was switched off
        // ----------------------------------------
        if (state_reg.grant.valid && !state_reg.ch[g].cfg.channel_on)
        begin
            state_next.grant.valid = 1'b0;
        end

        // ----------------------------------------
        // beat results for the granted channel
        // ----------------------------------------
        if (state_reg.grant.valid && (beat_done || beat_fault))
        begin
            state_next.grant.valid = 1'b0;
            if (beat_fault)
            begin
                // R4: fault event
                flag_set[g][FLAG_FAULT_BIT] = 1'b1;
                flag_set[g][FLAG_ANY_BIT] = 1'b1;
                state_next.ch[g].cfg.channel_on = 1'b0;
            end
            else
            begin
                // R20: count down per beat
                left = 16'(state_reg.ch[g].transfer_quantity - 16'd1);
                state_next.ch[g].transfer_quantity = left;
                // R10: address stepping
                if (state_reg.ch[g].cfg.periph_addr_step_enable)
                begin
                    state_next.ch[g].periph_addr = 32'(state_reg.ch[g].periph_addr
                        + step_of(state_reg.ch[g].cfg.periph_word_width));
                end
                if (state_reg.ch[g].cfg.memory_addr_step_enable)
                begin
                    state_next.ch[g].memory_addr = 32'(state_reg.ch[g].memory_addr
                        + step_of(state_reg.ch[g].cfg.memory_word_width));
                end
                // R3: halfway event
                if (left == (state_reg.ch[g].reload_quantity >> 1))
                begin
                    flag_set[g][FLAG_HALF_BIT] = 1'b1;
                    flag_set[g][FLAG_ANY_BIT] = 1'b1;
                end
                // R2: done event
                if (left == 16'd0)
                begin
                    flag_set[g][FLAG_DONE_BIT] = 1'b1;
                    flag_set[g][FLAG_ANY_BIT] = 1'b1;
                    // R9: wraparound reload
                    if (state_reg.ch[g].cfg.wraparound_enable)
                    begin
                        state_next.ch[g].transfer_quantity = state_reg.ch[g].reload_quantity;
                        state_next.ch[g].periph_addr = state_reg.ch[g].periph_base;
                        state_next.ch[g].memory_addr = state_reg.ch[g].memory_base;
                    end
                end
            end
        end

        // ----------------------------------------
        // software writes
        // ----------------------------------------
        if (wr_now && dec.is_clear)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                // R5: global clear
                if (pwdata[FLAG_STRIDE*i + FLAG_ANY_BIT])
                begin
                    flag_clr[i] = 4'hf;
                end
                // R6: single flag clears
                flag_clr[i][FLAG_DONE_BIT] |= pwdata[FLAG_STRIDE*i + FLAG_DONE_BIT];
                flag_clr[i][FLAG_HALF_BIT] |= pwdata[FLAG_STRIDE*i + FLAG_HALF_BIT];
                flag_clr[i][FLAG_FAULT_BIT] |= pwdata[FLAG_STRIDE*i + FLAG_FAULT_BIT];
            end
        end
        if (wr_now && dec.is_chan)
        begin
            case (dec.reg_ofs)
                CH_CONFIG_OFS:
                begin
                    // R7: enable and irq enables
                    // R8: direction
                    // R11: peripheral width
                    // R12: memory width
                    // R13: priority level
                    // R14: memory copy
                    state_next.ch[dec.chan].cfg = chan_cfg_t'(pwdata[CFG_W-1:0]);
                end
                CH_COUNT_OFS:
                begin
                    // R21: count locked while enabled
                    if (!state_reg.ch[dec.chan].cfg.channel_on)
                    begin
                        state_next.ch[dec.chan].transfer_quantity = pwdata[COUNT_W-1:0];
                        state_next.ch[dec.chan].reload_quantity = pwdata[COUNT_W-1:0];
                    end
                end
                CH_PADDR_OFS:
                begin
                    // R21: address locked while enabled
                    if (!state_reg.ch[dec.chan].cfg.channel_on)
                    begin
                        state_next.ch[dec.chan].periph_base = pwdata;
                        state_next.ch[dec.chan].periph_addr = pwdata;
                    end
                end
                CH_MADDR_OFS:
                begin
                    // R21: address locked while enabled
                    if (!state_reg.ch[dec.chan].cfg.channel_on)
                    begin
                        state_next.ch[dec.chan].memory_base = pwdata;
                        state_next.ch[dec.chan].memory_addr = pwdata;
                    end
                end
                default:
                begin
                    state_next.ch[dec.chan].cfg = state_reg.ch[dec.chan].cfg;
                end
            endcase
        end

        // ----------------------------------------
        // flag update, a set beats a clear in the same cycle
        // ----------------------------------------
        for (int i = 0; i < NUM_CH; i++)
        begin
            // R1: any-event flag follows the others
            state_next.ch[i].flags = chan_flags_t'((state_reg.ch[i].flags & ~flag_clr[i])
                | flag_set[i]);
        end

        // R19: arbiter, level first then lowest channel
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            // R20: zero count never transfers
            if (eligible(state_reg.ch[i], chan_request[i])
                && (!found || state_reg.ch[i].cfg.channel_priority_level >= best_pl))
            begin
                found = 1'b1;
                best_pl = state_reg.ch[i].cfg.channel_priority_level;
                best = 3'(i);
            end
        end
        // load the winner into the grant
        if (!state_reg.grant.valid && found)
        begin
            state_next.grant.valid = 1'b1;
            state_next.grant.channel = best;
            state_next.grant.transfer_direction = state_reg.ch[best].cfg.transfer_direction;
            state_next.grant.periph_word_width = state_reg.ch[best].cfg.periph_word_width;
            state_next.grant.memory_word_width = state_reg.ch[best].cfg.memory_word_width;
            state_next.grant.memory_copy_enable = state_reg.ch[best].cfg.memory_copy_enable;
            state_next.grant.periph_addr = state_reg.ch[best].periph_addr;
            state_next.grant.memory_addr = state_reg.ch[best].memory_addr;
        end

        // R22: per channel interrupt request
        for (int i = 0; i < NUM_CH; i++)
        begin
            state_next.irq[i] = (state_next.ch[i].flags.channel_done_flag
                    && state_next.ch[i].cfg.done_irq_enable)
                || (state_next.ch[i].flags.channel_halfway_flag
                    && state_next.ch[i].cfg.halfway_irq_enable)
                || (state_next.ch[i].flags.channel_fault_flag
                    && state_next.ch[i].cfg.fault_irq_enable);
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        // R17: everything clears at reset
        if (!presetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign grant = state_reg.grant;
    assign channel_irq = state_reg.irq[NUM_CH-1:0];

endmodule

//--- test/dma_channel_control_regs_assertions.sv
// port assertions of the dma channel control block
`timescale 1ns/1ps
module dma_channel_control_regs_assertions
    import dma_ctrl_pkg::*;
#(
    parameter int NUM_CH = 7
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_CH-1:0] chan_request,
    input wire logic beat_done,
    input wire logic beat_fault,
    input grant_t grant,
    input wire logic [NUM_CH-1:0] channel_irq
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    localparam int MAP_TOP = 8 + 20 * NUM_CH;
    logic acc;
    logic wr;
    logic cfg_hit;
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign cfg_hit = paddr >= 8 && int'(paddr) < MAP_TOP && (int'(paddr) - 8) % 20 == 0;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_one_wait;
        !pready ##1 pready;
    endsequence

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_ONE_WAIT:
        assert property (s_setup |=> s_one_wait) else $error("pready timing");
    AST_RDATA_IDLE:
        assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not idle");
    AST_ERR_WITH_READY:
        assert property (pslverr |-> pready) else $error("pslverr alone");
    AST_UNMAPPED:
        assert property (acc && paddr[1:0] == 2'b00 |-> pslverr == (int'(paddr) >= MAP_TOP
            || (paddr >= 8 && (int'(paddr) - 8) % 20 == 16))) else $error("pslverr wrong");
    AST_STATUS_RSVD:
        assert property (acc && !pwrite && paddr == EVENT_STATUS_OFS |-> prdata[31:28] == 4'h0)
        else $error("status reserved set");
    AST_CLEAR_READ:
        assert property (acc && !pwrite && paddr == EVENT_FLAG_CLEAR_OFS |-> prdata == 32'h0)
        else $error("clear read not zero");
    AST_CFG_RSVD:
        assert property (acc && !pwrite && cfg_hit |-> prdata[31:15] == 17'h0)
        else $error("config reserved set");
    AST_GRANT_HOLD:
        assert property (grant.valid && !beat_done && !beat_fault && !wr && !$past(wr)
            |=> $stable(grant)) else $error("grant moved");
    AST_GRANT_DROP:
        assert property (grant.valid && (beat_done || beat_fault) |=> !grant.valid)
        else $error("grant kept");
    AST_GRANT_REQ:
        assert property ($rose(grant.valid) && !grant.memory_copy_enable
            |-> (($past(chan_request) >> grant.channel) & 1) != 0) else $error("grant no request");
    AST_IRQ_CAUSE:
        assert property ((channel_irq & ~$past(channel_irq)) != 0
            |-> $past(beat_done || beat_fault || wr)) else $error("irq without cause");
endmodule

bind dma_channel_control_regs dma_channel_control_regs_assertions #(.NUM_CH(NUM_CH)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_request(chan_request), .beat_done(beat_done), .beat_fault(beat_fault),
    .grant(grant), .channel_irq(channel_irq)
);

//--- test/dma_far_side_model.sv
// memory and peripheral side answering one beat per grant
`timescale 1ns/1ps
module dma_far_side_model
    import dma_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input grant_t grant,
    input wire logic fault_mode,
    input wire logic [3:0] wait_cycles,
    output logic beat_done,
    output logic beat_fault
);
    logic [3:0] wait_reg;
    logic sent_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_reg <= 4'h0;
            sent_reg <= 1'b0;
            beat_done <= 1'b0;
            beat_fault <= 1'b0;
        end
        else
        begin
            beat_done <= 1'b0;
            beat_fault <= 1'b0;
            if (!grant.valid)
            begin
                wait_reg <= 4'h0;
                sent_reg <= 1'b0;
            end
            else if (!sent_reg && wait_reg == wait_cycles)
            begin
                beat_done <= !fault_mode;
                beat_fault <= fault_mode;
                sent_reg <= 1'b1;
            end
            else if (!sent_reg)
                wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule

//--- test/dma_channel_control_regs_tb.sv
// self-checking bench of the dma channel control block
`timescale 1ns/1ps
module dma_channel_control_regs_tb
    import dma_ctrl_pkg::*;
;
    logic pclk;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [6:0] chan_request = 7'h00;
    logic beat_done;
    logic beat_fault;
    grant_t grant;
    grant_t g;
    logic [6:0] channel_irq;
    logic fault_mode = 1'b0;
    logic [3:0] wait_cycles = 4'h0;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int i;

    dma_channel_control_regs #(.NUM_CH(7)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_request(chan_request), .beat_done(beat_done), .beat_fault(beat_fault),
        .grant(grant), .channel_irq(channel_irq)
    );
    dma_far_side_model far (
        .pclk(pclk), .presetn(presetn), .grant(grant), .fault_mode(fault_mode),
        .wait_cycles(wait_cycles), .beat_done(beat_done), .beat_fault(beat_fault)
    );

    // ----------------------------------------
    // clock, timeout and tasks
    // ----------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end
    task automatic complete_run();
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rd);
    endtask
    function automatic logic [7:0] cfg(input int ch);
        return 8'(8 + 20 * ch);
    endfunction
    task automatic setup_ch(input int ch, input logic [15:0] n, input logic [31:0] v);
        apb(1'b1, cfg(ch) + 8'h04, {16'h0000, n});
        apb(1'b1, cfg(ch) + 8'h08, 32'h0000_0100);
        apb(1'b1, cfg(ch) + 8'h0c, 32'h0000_0200);
        apb(1'b1, cfg(ch), v);
    endtask
    task automatic next_grant();
        do
            @(posedge pclk);
        while (grant.valid !== 1'b1);
        g = grant;
        do
            @(posedge pclk);
        while (grant.valid === 1'b1);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("status", 8'h00, 32'h0);
        rd_chk("clear", 8'h04, 32'h0);
        for (i = 0; i < 7; i++)
            rd_chk("config", cfg(i), 32'h0);
        chk("mapped err", 32'h0, {31'h0, er});
        rd_chk("unmapped", 8'h94, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        rd_chk("gap", 8'h18, 32'h0);
        chk("gap err", 32'h1, {31'h0, er});
        for (i = 1; i < 15; i++)
        begin
            apb(1'b1, cfg(i % 7), 32'h1 << i);
            rd_chk("config bit", cfg(i % 7), 32'h1 << i);
        end
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, cfg(i), 32'hffff_8000 | 32'(i * 32'h1500));
            rd_chk("config code", cfg(i), 32'(i * 32'h1500));
        end
        wait_cycles <= 4'h3;
        setup_ch(2, 16'h0004, 32'h0000_09c7);
        chan_request <= 7'h04;
        for (i = 0; i < 4; i++)
        begin
            next_grant();
            chk("grant chan", 32'h2, {29'h0, g.channel});
            chk("grant paddr", 32'h0000_0100 + 2 * i, g.periph_addr);
            chk("grant maddr", 32'h0000_0200 + 4 * i, g.memory_addr);
            chk("widths", 32'h9, {28'h0, g.memory_word_width, g.periph_word_width});
        end
        repeat (8) @(posedge pclk);
        chk("idle grant", 32'h0, {31'h0, grant.valid});
        rd_chk("count", cfg(2) + 8'h04, 32'h0);
        rd_chk("status done", 8'h00, 32'h0000_0700);
        chk("irq", 32'h04, {25'h0, channel_irq});
        apb(1'b1, 8'h00, 32'hffff_ffff);
        apb(1'b1, 8'h04, 32'h0000_0400);
        rd_chk("half clr", 8'h00, 32'h0000_0300);
        apb(1'b1, 8'h04, 32'h0000_0000);
        rd_chk("zero clr", 8'h00, 32'h0000_0300);
        apb(1'b1, 8'h04, 32'h0000_0100);
        rd_chk("glob clr", 8'h00, 32'h0);
        chk("irq off", 32'h0, {25'h0, channel_irq});
        chan_request <= 7'h00;
        wait_cycles <= 4'h0;
        setup_ch(0, 16'h0001, 32'h0000_0501);
        setup_ch(3, 16'h0001, 32'h0000_2501);
        setup_ch(5, 16'h0001, 32'h0000_2511);
        chan_request <= 7'h29;
        next_grant();
        chk("first", 32'h3, {29'h0, g.channel});
        next_grant();
        chk("second", 32'h5, {29'h0, g.channel});
        chk("dir", 32'h1, {31'h0, g.transfer_direction});
        next_grant();
        chk("third", 32'h0, {29'h0, g.channel});
        chan_request <= 7'h00;
        repeat (3) @(posedge pclk);
        rd_chk("status one", 8'h00, 32'h0070_7007);
        chk("irq gated", 32'h0, {25'h0, channel_irq});
        setup_ch(6, 16'h0003, 32'h0000_0509);
        apb(1'b1, cfg(6) + 8'h04, 32'h0000_0009);
        rd_chk("locked cnt", cfg(6) + 8'h04, 32'h3);
        apb(1'b1, cfg(6) + 8'h08, 32'h0000_0abc);
        rd_chk("locked adr", cfg(6) + 8'h08, 32'h0000_0100);
        fault_mode <= 1'b1;
        chan_request <= 7'h40;
        next_grant();
        chan_request <= 7'h00;
        repeat (3) @(posedge pclk);
        rd_chk("fault st", 8'h00, 32'h0970_7007);
        rd_chk("fault off", cfg(6), 32'h0000_0508);
        chk("fault irq", 32'h40, {25'h0, channel_irq});
        fault_mode <= 1'b0;
        setup_ch(1, 16'h0001, 32'h0000_4501);
        next_grant();
        chk("copy chan", 32'h1, {29'h0, g.channel});
        chk("copy mode", 32'h1, {31'h0, g.memory_copy_enable});
        complete_run();
    end
endmodule
